// >>> hw/basic_counter_pkg.sv
package basic_counter_pkg;
    // register indices on the plain register port
    localparam logic [1:0] ADDR_COUNT_LOW = 2'h0;
    localparam logic [1:0] ADDR_COUNT_HIGH = 2'h1;
    localparam logic [1:0] ADDR_INTERRUPT_CONTROL = 2'h2;
    localparam logic [1:0] ADDR_TIMER_CONTROL = 2'h3;
    // timer_control fields
    localparam int CTRL_TIMER_ON = 7;
    localparam int CTRL_BYTE_MODE = 6;
    localparam int CTRL_CLOCK_SOURCE = 5;
    localparam int CTRL_EDGE_SELECT = 4;
    localparam int CTRL_PRESCALER_BYPASS = 3;
    localparam int CTRL_RATIO_MSB = 2;
    // interrupt_control fields
    localparam int INTC_OVERFLOW_IRQ_ENABLE = 5;
    localparam int INTC_OVERFLOW_FLAG = 2;
    // reset values
    localparam logic [7:0] TIMER_CONTROL_RESET = 8'hff;
    localparam logic [7:0] INTERRUPT_CONTROL_RESET = 8'h00;
    localparam logic [7:0] COUNT_BYTE_RESET = 8'h00;
    localparam logic [7:0] PRESCALE_RESET = 8'h00;
endpackage

// >>> hw/prescale_divider.sv
`timescale 1ns/1ps
`default_nettype none
module prescale_divider #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic tick_in,
    input wire logic clear,
    input wire logic [2:0] ratio,
    output logic tick_out
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] top;

    // divide by 2 << ratio
    always_comb begin
        top = WIDTH'((2 << ratio) - 1);
    end

    // hidden counter, not readable; cleared by count writes unless bypassed
    always_ff @(posedge clk_sys) begin
        if (rst || clear) begin
            count <= WIDTH'(basic_counter_pkg::PRESCALE_RESET);
        end else if (tick_in) begin
            count <= (count == top) ? '0 : count + WIDTH'(1);
        end
    end

    always_comb begin
        tick_out = tick_in && !clear && (count == top);
    end
endmodule
`default_nettype wire

// >>> hw/basic_counter_unit.sv
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module basic_counter_unit (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic instr_tick,
    input wire logic ext_clock_in,
    input wire logic sleep,
    output logic overflow_irq
);
    logic [7:0] timer_control;
    logic [7:0] interrupt_control;
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic [7:0] high_buffer;
    logic ext_prev;
    logic ext_edge;
    logic source_tick;
    logic pre_tick;
    logic count_tick;
    logic count_write;
    logic wrap;
    logic bypass;

    assign bypass = timer_control[basic_counter_pkg::CTRL_PRESCALER_BYPASS];
    // any write to either count byte counts as a count write
    assign count_write = reg_write &&
        (reg_addr == basic_counter_pkg::ADDR_COUNT_LOW ||
         reg_addr == basic_counter_pkg::ADDR_COUNT_HIGH);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ext_prev <= 1'b0;
        end else begin
            ext_prev <= ext_clock_in;
        end
    end

    // rising when edge select clear, falling when set
    always_comb begin
        if (timer_control[basic_counter_pkg::CTRL_EDGE_SELECT]) begin
            ext_edge = ext_prev && !ext_clock_in;
        end else begin
            ext_edge = !ext_prev && ext_clock_in;
        end
    end

    always_comb begin
        source_tick = timer_control[basic_counter_pkg::CTRL_TIMER_ON]
            && !sleep
            && (timer_control[basic_counter_pkg::CTRL_CLOCK_SOURCE]
                ? ext_edge : instr_tick);
    end

    prescale_divider #(
        .WIDTH(8)
    ) u_prescale (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick_in(source_tick && !bypass),
        .clear(count_write && !bypass),
        .ratio(timer_control[basic_counter_pkg::CTRL_RATIO_MSB:0]),
        .tick_out(pre_tick)
    );

    // bypass read live each cycle, so switching needs no stop
    always_comb begin
        count_tick = (bypass ? source_tick : pre_tick) && !count_write;
    end

    always_comb begin
        if (timer_control[basic_counter_pkg::CTRL_BYTE_MODE]) begin
            wrap = count_tick && count_low_byte == 8'hff;
        end else begin
            wrap = count_tick && count_low_byte == 8'hff &&
                count_high_byte == 8'hff;
        end
    end

    // timer_control; count writes never touch it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            timer_control <= basic_counter_pkg::TIMER_CONTROL_RESET;
        end else if (reg_write &&
                     reg_addr == basic_counter_pkg::ADDR_TIMER_CONTROL) begin
            timer_control <= reg_wdata;
        end
    end

    // high byte written via buffer, loaded with low byte write
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            high_buffer <= basic_counter_pkg::COUNT_BYTE_RESET;
        end else if (reg_write &&
                     reg_addr == basic_counter_pkg::ADDR_COUNT_HIGH) begin
            high_buffer <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_low_byte <= basic_counter_pkg::COUNT_BYTE_RESET;
            count_high_byte <= basic_counter_pkg::COUNT_BYTE_RESET;
        end else if (reg_write &&
                     reg_addr == basic_counter_pkg::ADDR_COUNT_LOW) begin
            count_low_byte <= reg_wdata;
            count_high_byte <= high_buffer;
        end else if (count_tick) begin
            count_low_byte <= count_low_byte + 8'h01;
            if (!timer_control[basic_counter_pkg::CTRL_BYTE_MODE] &&
                count_low_byte == 8'hff) begin
                count_high_byte <= count_high_byte + 8'h01;
            end
        end
    end

    // flag set wins over a software clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            interrupt_control <= basic_counter_pkg::INTERRUPT_CONTROL_RESET;
        end else begin
            if (reg_write &&
                reg_addr == basic_counter_pkg::ADDR_INTERRUPT_CONTROL) begin
                interrupt_control <= reg_wdata;
            end
            if (wrap) begin
                interrupt_control[basic_counter_pkg::INTC_OVERFLOW_FLAG]
                    <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            overflow_irq <= 1'b0;
        end else begin
            overflow_irq <=
                interrupt_control[basic_counter_pkg::INTC_OVERFLOW_FLAG] &&
                interrupt_control[
                    basic_counter_pkg::INTC_OVERFLOW_IRQ_ENABLE];
        end
    end

    // high read returns live high byte; prescaler is not mapped
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                basic_counter_pkg::ADDR_COUNT_LOW:
                    reg_rdata <= count_low_byte;
                basic_counter_pkg::ADDR_COUNT_HIGH:
                    reg_rdata <= count_high_byte;
                basic_counter_pkg::ADDR_INTERRUPT_CONTROL:
                    reg_rdata <= interrupt_control;
                basic_counter_pkg::ADDR_TIMER_CONTROL:
                    reg_rdata <= timer_control;
                default:
                    reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// >>> bench/basic_counter_chk.sv
`timescale 1ns/1ps
`default_nettype none
module basic_counter_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic instr_tick,
    input wire logic ext_clock_in,
    input wire logic sleep,
    input wire logic overflow_irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire logic rd0 = reg_read && reg_addr == 2'h0 && !reg_write;
    wire logic rd2 = reg_read && reg_addr == 2'h2 && !reg_write;
    AST_IDLE: assert property (!reg_read |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    AST_RST: assert property (
        $fell(rst) |-> !overflow_irq && !reg_rdata)
        else $error("outputs not cleared by reset");
    AST_CTRL_RST: assert property (
        $fell(rst) && reg_read && reg_addr == 2'h3
        |=> reg_rdata == 8'hff)
        else $error("control reset value wrong");
    AST_CTRL_RB: assert property (
        reg_write && reg_addr == 2'h3 ##1 reg_read && reg_addr == 2'h3
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("control readback wrong");
    AST_INTC_RB: assert property (
        reg_write && reg_addr == 2'h2 ##1 rd2
        |=> reg_rdata[5] == $past(reg_wdata[5], 2))
        else $error("irq enable readback wrong");
    AST_MASK: assert property (
        rd2 |=> overflow_irq == (reg_rdata[5] && reg_rdata[2]))
        else $error("irq not flag and enable");
    AST_SLEEP: assert property (
        rd0 && sleep ##1 rd0 |=> $stable(reg_rdata))
        else $error("count moved in sleep");
    AST_STICKY: assert property (
        rd2 ##1 rd2 |=> !$past(reg_rdata[2]) || reg_rdata[2])
        else $error("flag cleared by itself");
    cover property ($rose(overflow_irq));
    cover property (rd0 && sleep ##1 rd0);
    cover property (reg_write && reg_addr == 2'h0);
endmodule
bind basic_counter_unit basic_counter_chk chk_u (.*);
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys = 0, rst = 1, reg_write = 0, reg_read = 0, f;
    logic instr_tick = 0, ext_clock_in = 0, sleep = 0, overflow_irq;
    logic [1:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata, q, c, ie;
    logic [15:0] st, e;
    int num_errors = 0, checked = 0, cyc = 0, k, n;
    basic_counter_unit dut_u (.*);
    initial forever #50 clk_sys = ~clk_sys;
    task report_and_stop;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [7:0] g, input logic [7:0] x);
        checked++;
        if (g !== x) begin
            num_errors++;
            $display("Error %0t: got %h expected %h", $time, g, x);
        end
    endtask
    // one register cycle; read data taken in the following cycle
    task op(input logic w, input logic [1:0] a, input logic [7:0] d);
        reg_write <= w;
        reg_read <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_write <= 0;
        reg_read <= 0;
        #1 q = reg_rdata;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc > 20000) begin
            num_errors++;
            report_and_stop;
        end
    end
    initial begin
        void'($urandom(32'haf20));
        repeat (5) @(posedge clk_sys);
        rst <= 0;
        op(0, 2'h3, 0);
        chk(q, 8'hff);
        op(0, 2'h2, 0);
        chk(q, 8'h00);
        repeat (14) begin
            c = $urandom;
            c[7] = ($urandom % 4) != 0;
            ie = ($urandom % 2) ? 8'h20 : 8'h00;
            st = {($urandom % 2) ? 8'hff : 8'($urandom), 8'hf0 | 8'($urandom)};
            k = 1 + $urandom % 40;
            sleep <= ($urandom % 4) == 0;
            ext_clock_in <= 0;
            repeat (3) @(posedge clk_sys) #1;
            op(1, 2'h3, c);
            op(0, 2'h3, 0);
            chk(q, c);
            op(1, 2'h2, ie);
            op(0, 2'h2, 0);
            chk(q, ie);
            op(1, 2'h1, st[15:8]);
            op(1, 2'h0, st[7:0]);
            // internal ticks every cycle, external pulses every two
            for (int j = 0; j <= 2 * k; j++) begin
                instr_tick <= 1;
                ext_clock_in <= !j[0];
                @(posedge clk_sys) #1;
            end
            instr_tick <= 0;
            repeat (4) @(posedge clk_sys) #1;
            n = c[5] ? k + !c[4] : 2 * k + 1;
            if (!c[3]) n = n / (2 << c[2:0]);
            if (!c[7] || sleep) n = 0;
            e = c[6] ? {st[15:8], st[7:0] + 8'(n)} : st + 16'(n);
            f = c[6] ? st[7:0] + n > 255 : st + n > 65535;
            op(0, 2'h0, 0);
            op(0, 2'h0, 0);
            chk(q, e[7:0]);
            op(0, 2'h1, 0);
            chk(q, e[15:8]);
            op(0, 2'h3, 0);
            chk(q, c);
            op(0, 2'h2, 0);
            op(0, 2'h2, 0);
            chk(q, ie | {5'b0, f, 2'b0});
            chk({7'b0, overflow_irq}, {7'b0, f & ie[5]});
        end
        report_and_stop;
    end
endmodule
`default_nettype wire
